// ===== shared/pmes_regs.svh
// register indices, field positions, reset values and fixed port addresses
// assumes the register bus uses byte addresses, one aligned word per register
`ifndef PMES_REGS_SVH
`define PMES_REGS_SVH

// register indices; the byte address is four times the index
`define PMES_IDX_WINDOW_LOW 8'h5E
`define PMES_IDX_WINDOW_HIGH 8'h5F
`define PMES_IDX_SYS_SEL_1 8'h77
`define PMES_IDX_SYS_SEL_2 8'h78
`define PMES_IDX_BRK_SEL_0 8'h79
`define PMES_IDX_BRK_SEL_1 8'h7A
`define PMES_IDX_BRK_SEL_2 8'h7B
`define PMES_IDX_SMI_CAUSE_0 8'h7C
`define PMES_IDX_SMI_CAUSE_1 8'h7D
`define PMES_IDX_CONTROL 8'h80

// reset values
`define PMES_RST_BYTE 8'h00

// control register fields
`define PMES_CTL_BREAK_SMI_EN 0
`define PMES_CTL_AUTO_SUSP_EN 2

// window high byte fields
`define PMES_WIN_MASK_LSB 2
`define PMES_WIN_MASK_MSB 5

// fixed legacy port addresses and the low address bits each one spans
`define PMES_PORT_3BC 10'h3BC
`define PMES_PORT_278 10'h278
`define PMES_PORT_378 10'h378
`define PMES_PORT_2F8 10'h2F8
`define PMES_PORT_3F8 10'h3F8
`define PMES_SPAN_PAR 10'h003
`define PMES_SPAN_SER 10'h007

`endif

// ===== shared/pmes_pkg.sv
// types shared by the event select and smi cause block
// assumes the constants header is included by the design file
package pmes_pkg;
    typedef logic [7:0] pmes_byte_t;
    typedef logic [9:0] pmes_ioaddr_t;
    typedef logic [23:0] pmes_evvec_t;
    typedef enum logic [0:0] {
        PHASE_IDLE,
        PHASE_ANSWER
    } pmes_phase_e;
endpackage

// ===== design/pmes_event_select.sv
// power-management event selection and smi cause recording, one clock domain
// assumes all event inputs and the register bus are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "pmes_regs.svh"

module pmes_event_select (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [9:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic [15:0] irqLines,
    input wire logic dmaRequest,
    input wire logic alarm,
    input wire logic ringN,
    input wire logic external_system_event_pinN,
    input wire logic hddAccess,
    input wire pmes_pkg::pmes_ioaddr_t ioAddr,
    input wire logic ioRead,
    input wire logic ioWrite,
    input wire logic globalStandbyExitReq,
    input wire logic globalStandbyEnterReq,
    input wire logic displayStandbyExitReq,
    input wire logic displayStandbyEnterReq,
    input wire logic windowStandbyExitReq,
    input wire logic windowStandbyEnterReq,
    input wire logic diskStandbyExitReq,
    input wire logic diskStandbyEnterReq,
    input wire logic acPower,
    input wire logic extSmi1Req,
    input wire logic extSmi0Req,
    input wire logic softwareSmiReq,
    input wire logic batteryLowReq,
    input wire logic suspendButtonReq,
    input wire logic autoSuspendReq,
    output logic systemEvent,
    output logic breakEvent,
    output logic breakSmi,
    output logic autoSuspendTrigger,
    output logic smiPending
);
    import pmes_pkg::*;

    // hit on a fixed port; span marks the low bits that do not take part
    // the port blocks are fixed in hardware; software cannot move them
    function automatic logic portHit(input pmes_ioaddr_t addr, input pmes_ioaddr_t base,
                                     input pmes_ioaddr_t span);
        portHit = ((addr & ~span) == (base & ~span));
    endfunction

    // device window compare, each masked low bit left out of the compare
    function automatic logic windowHit(input pmes_ioaddr_t addr, input pmes_byte_t lowByte,
                                       input pmes_byte_t highByte);
        logic [9:0] base;
        logic [9:0] care;
        base = {highByte[1:0], lowByte};
        care = {6'h3F, ~highByte[`PMES_WIN_MASK_MSB:`PMES_WIN_MASK_LSB]};
        windowHit = ((addr & care) == (base & care));
    endfunction

    // set wins over a clearing write; a written one leaves the bit as it was
    // so a cause that lands during a software clear is never lost
    function automatic pmes_byte_t causeNext(input pmes_byte_t cur, input pmes_byte_t set,
                                             input logic clr, input pmes_byte_t data);
        pmes_byte_t keep;
        keep = clr ? (cur & data) : cur;
        causeNext = keep | set;
    endfunction

    // bus state
    pmes_phase_e phaseQ, phaseD;
    logic waitQ, waitD;
    logic [31:0] rdataQ, rdataD;

    // configuration registers
    pmes_byte_t winLowQ, winLowD;
    pmes_byte_t winHighQ, winHighD;
    pmes_byte_t sysSel1Q, sysSel1D;
    pmes_byte_t sysSel2Q, sysSel2D;
    pmes_byte_t brkSel0Q, brkSel0D;
    pmes_byte_t brkSel1Q, brkSel1D;
    pmes_byte_t brkSel2Q, brkSel2D;
    pmes_byte_t controlQ, controlD;

    // cause registers
    pmes_byte_t cause0Q, cause0D;
    pmes_byte_t cause1Q, cause1D;

    // event state
    pmes_evvec_t levelPrevQ, levelPrevD;
    logic acPrevQ, acPrevD;
    logic acValidQ, acValidD;
    logic sysEvQ, sysEvD;
    logic brkEvQ, brkEvD;
    logic brkSmiQ, brkSmiD;
    logic autoTrigQ, autoTrigD;
    logic pendQ, pendD;

    // decoded bus access
    logic [7:0] regIndex;
    logic wrTake;
    logic wrByte0;
    pmes_byte_t wrData;

    // event vectors
    pmes_evvec_t levelNow;
    pmes_evvec_t edgeNow;
    pmes_evvec_t eventNow;
    pmes_evvec_t sysMask;
    pmes_evvec_t brkMask;
    logic ioAccess;
    pmes_byte_t ioHits;
    pmes_byte_t set0;
    pmes_byte_t set1;

    // the write lands on the edge where waitrequest is seen low
    // address bits 1:0 are ignored; each register sits in its own word
    assign regIndex = avsAddress[9:2];
    assign wrTake = avsWrite && (phaseQ == PHASE_ANSWER);
    assign wrByte0 = wrTake && avsByteEnable[0];
    assign wrData = avsWriteData[7:0];

    // bus phase: one wait cycle, then the answer; a request still held after the answer is served again
    // read data are latched when the request is taken, so a cause that sets
    // during the wait cycle shows on the next read, not on this one
    always_comb begin
        phaseD = phaseQ;
        waitD = 1'b1;
        rdataD = rdataQ;
        unique case (phaseQ)
            PHASE_IDLE: begin
                if (avsRead || avsWrite) begin
                    phaseD = PHASE_ANSWER;
                    waitD = 1'b0;
                    rdataD = 32'h0000_0000;
                    if (avsRead) begin
                        // unmapped indices read as zero, upper bits always zero
                        case (regIndex)
                            `PMES_IDX_WINDOW_LOW: rdataD[7:0] = winLowQ;
                            `PMES_IDX_WINDOW_HIGH: rdataD[7:0] = winHighQ;
                            `PMES_IDX_SYS_SEL_1: rdataD[7:0] = sysSel1Q;
                            `PMES_IDX_SYS_SEL_2: rdataD[7:0] = sysSel2Q;
                            `PMES_IDX_BRK_SEL_0: rdataD[7:0] = brkSel0Q;
                            `PMES_IDX_BRK_SEL_1: rdataD[7:0] = brkSel1Q;
                            `PMES_IDX_BRK_SEL_2: rdataD[7:0] = brkSel2Q;
                            `PMES_IDX_SMI_CAUSE_0: rdataD[7:0] = cause0Q;
                            `PMES_IDX_SMI_CAUSE_1: rdataD[7:0] = cause1Q;
                            `PMES_IDX_CONTROL: rdataD[7:0] = controlQ;
                            default: rdataD[7:0] = `PMES_RST_BYTE;
                        endcase
                    end
                end
            end
            PHASE_ANSWER: begin
                phaseD = PHASE_IDLE;
                waitD = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phaseQ <= PHASE_IDLE;
            waitQ <= 1'b1;
            rdataQ <= 32'h0000_0000;
        end else begin
            phaseQ <= phaseD;
            waitQ <= waitD;
            rdataQ <= rdataD;
        end
    end

    assign avsReadData = rdataQ;
    assign avsWaitRequest = waitQ;

    // configuration writes; only byte lane 0 carries register data
    // window high bits 7 and 6 are stored and read back only; the window compare ignores them
    always_comb begin
        winLowD = winLowQ;
        winHighD = winHighQ;
        sysSel1D = sysSel1Q;
        sysSel2D = sysSel2Q;
        brkSel0D = brkSel0Q;
        brkSel1D = brkSel1Q;
        brkSel2D = brkSel2Q;
        controlD = controlQ;
        if (wrByte0) begin
            case (regIndex)
                `PMES_IDX_WINDOW_LOW: winLowD = wrData;
                `PMES_IDX_WINDOW_HIGH: winHighD = wrData;
                `PMES_IDX_SYS_SEL_1: sysSel1D = wrData;
                `PMES_IDX_SYS_SEL_2: sysSel2D = wrData;
                `PMES_IDX_BRK_SEL_0: brkSel0D = wrData;
                `PMES_IDX_BRK_SEL_1: brkSel1D = wrData;
                `PMES_IDX_BRK_SEL_2: brkSel2D = wrData;
                `PMES_IDX_CONTROL: controlD = wrData;
                default: controlD = controlQ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            winLowQ <= `PMES_RST_BYTE;
            winHighQ <= `PMES_RST_BYTE;
            sysSel1Q <= `PMES_RST_BYTE;
            sysSel2Q <= `PMES_RST_BYTE;
            brkSel0Q <= `PMES_RST_BYTE;
            brkSel1Q <= `PMES_RST_BYTE;
            brkSel2Q <= `PMES_RST_BYTE;
            controlQ <= `PMES_RST_BYTE;
        end else begin
            winLowQ <= winLowD;
            winHighQ <= winHighD;
            sysSel1Q <= sysSel1D;
            sysSel2Q <= sysSel2D;
            brkSel0Q <= brkSel0D;
            brkSel1Q <= brkSel1D;
            brkSel2Q <= brkSel2D;
            controlQ <= controlD;
        end
    end

    // i/o access decode against the window and the fixed legacy ports
    // reads and writes count alike, one event for every cycle with a hit
    // a window that overlaps a fixed port raises both bits; each is selected apart
    assign ioAccess = ioRead || ioWrite;
    always_comb begin
        ioHits = 8'h00;
        ioHits[7] = 1'b0;
        ioHits[6] = ioAccess && windowHit(ioAddr, winLowQ, winHighQ);
        ioHits[5] = 1'b0;
        ioHits[4] = ioAccess && portHit(ioAddr, `PMES_PORT_3BC, `PMES_SPAN_PAR);
        ioHits[3] = ioAccess && portHit(ioAddr, `PMES_PORT_278, `PMES_SPAN_PAR);
        ioHits[2] = ioAccess && portHit(ioAddr, `PMES_PORT_378, `PMES_SPAN_PAR);
        ioHits[1] = ioAccess && portHit(ioAddr, `PMES_PORT_2F8, `PMES_SPAN_SER);
        ioHits[0] = ioAccess && portHit(ioAddr, `PMES_PORT_3F8, `PMES_SPAN_SER);
    end

    // level sources count on their rising edge so a held line is one event;
    // i/o port and window hits already are events and bypass the edge stage
    assign levelNow = {dmaRequest, alarm, ~ringN, irqLines[15:11],
                       ~external_system_event_pinN, 1'b0, hddAccess, 5'h00,
                       irqLines[10:9], irqLines[7:3], irqLines[1]};
    assign edgeNow = levelNow & ~levelPrevQ;
    assign eventNow = {edgeNow[23:16], edgeNow[15], ioHits[6], edgeNow[13], ioHits[4:0], edgeNow[7:0]};

    // select masks per path; the system path has no low byte here
    // interrupt lines 0, 2 and 8 have no select bit and are never looked at
    assign sysMask = {sysSel1Q, sysSel2Q, 8'h00};
    assign brkMask = {brkSel1Q, brkSel2Q, brkSel0Q};

    // event outputs and break smi; gating each path on its own mask
    // break smi and the trigger rise with the break event, never a cycle later
    // registering costs one cycle of latency but keeps every output glitch free
    always_comb begin
        levelPrevD = levelNow;
        sysEvD = |(eventNow & sysMask);
        brkEvD = |(eventNow & brkMask);
        brkSmiD = brkEvD && controlQ[`PMES_CTL_BREAK_SMI_EN];
        autoTrigD = brkSmiD && controlQ[`PMES_CTL_AUTO_SUSP_EN];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            levelPrevQ <= 24'h00_0000;
            sysEvQ <= 1'b0;
            brkEvQ <= 1'b0;
            brkSmiQ <= 1'b0;
            autoTrigQ <= 1'b0;
        end else begin
            levelPrevQ <= levelPrevD;
            sysEvQ <= sysEvD;
            brkEvQ <= brkEvD;
            brkSmiQ <= brkSmiD;
            autoTrigQ <= autoTrigD;
        end
    end

    assign systemEvent = sysEvQ;
    assign breakEvent = brkEvQ;
    assign breakSmi = brkSmiQ;
    assign autoSuspendTrigger = autoTrigQ;

    // ac power edges; the first sample after reset only primes the history,
    // so a board that powers up on ac does not log a false rising edge
    // the price: an ac change in the very first cycle after reset is missed
    always_comb begin
        acPrevD = acPower;
        acValidD = 1'b1;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acPrevQ <= 1'b0;
            acValidQ <= 1'b0;
        end else begin
            acPrevQ <= acPrevD;
            acValidQ <= acValidD;
        end
    end

    // cause set vectors
    // requests are pulses; a request held high keeps setting its bit,
    // so software should clear only after the source has let go
    always_comb begin
        set0 = 8'h00;
        set1 = 8'h00;
        set0[7] = globalStandbyExitReq;
        set0[6] = globalStandbyEnterReq;
        set0[5] = displayStandbyExitReq;
        set0[4] = displayStandbyEnterReq;
        set0[3] = windowStandbyExitReq;
        set0[2] = windowStandbyEnterReq;
        set0[1] = diskStandbyExitReq;
        set0[0] = diskStandbyEnterReq;
        set1[7] = acValidQ && acPrevQ && !acPower;
        set1[6] = acValidQ && !acPrevQ && acPower;
        set1[5] = extSmi1Req;
        set1[4] = extSmi0Req;
        set1[3] = softwareSmiReq;
        set1[2] = batteryLowReq;
        set1[1] = suspendButtonReq;
        set1[0] = autoSuspendReq;
    end

    // sticky causes, cleared per bit by writing zero
    // pending is taken from the next values so it never lags its register
    always_comb begin
        cause0D = causeNext(cause0Q, set0, wrByte0 && (regIndex == `PMES_IDX_SMI_CAUSE_0), wrData);
        cause1D = causeNext(cause1Q, set1, wrByte0 && (regIndex == `PMES_IDX_SMI_CAUSE_1), wrData);
        pendD = (|cause0D) || (|cause1D);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cause0Q <= `PMES_RST_BYTE;
            cause1Q <= `PMES_RST_BYTE;
            pendQ <= 1'b0;
        end else begin
            cause0Q <= cause0D;
            cause1Q <= cause1D;
            pendQ <= pendD;
        end
    end

    // pending follows the cause registers in the same edge
    assign smiPending = pendQ;

endmodule
`default_nettype wire

// ===== sim/pmes_host_model.sv
// host side model: counts break smi pulses and notes any pending smi level
// assumes smi pulses last one mclk cycle and are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module pmes_host_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic breakSmi,
    input wire logic smiPending,
    output logic [15:0] smiCount,
    output logic pendingSeen
);
    logic [15:0] smiCount_d;
    logic pendingSeen_d;
    // a pulse is one request, so count per high cycle and never per edge
    always_comb begin
        smiCount_d = smiCount + {15'h0000, breakSmi};
        pendingSeen_d = pendingSeen | smiPending;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            smiCount <= 16'h0000;
            pendingSeen <= 1'b0;
        end else begin
            smiCount <= smiCount_d;
            pendingSeen <= pendingSeen_d;
        end
    end
endmodule
`default_nettype wire

// ===== sim/pmes_event_select_properties.sv
// port-level checker for the event select and smi cause block
// assumes one clock domain with rst asynchronous, active high
`timescale 1ns/1ps
`default_nettype none
module pmes_event_select_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    input wire logic acPower,
    input wire logic softwareSmiReq,
    input wire logic globalStandbyExitReq,
    input wire logic breakEvent,
    input wire logic breakSmi,
    input wire logic autoSuspendTrigger,
    input wire logic smiPending
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // bus answers after exactly one wait cycle and only for one cycle
    req_answer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("request not answered in the next cycle");
    answer_once_a: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("answer lasted more than one cycle");
    data_hold_a: assert property (avsWaitRequest && $past(avsWaitRequest) |-> $stable(avsReadData))
        else $error("read data moved between answers");
    // smi follows its break event, the auto suspend trigger follows the smi
    break_smi_a: assert property (breakSmi |-> breakEvent)
        else $error("break smi without break event");
    auto_trig_a: assert property (autoSuspendTrigger |-> breakSmi)
        else $error("auto suspend trigger without break smi");
    // a recorded cause shows as pending one cycle later
    sw_cause_a: assert property (softwareSmiReq |=> smiPending)
        else $error("software request not pending");
    standby_exit_a: assert property (globalStandbyExitReq |=> smiPending)
        else $error("standby exit request not pending");
    ac_cause_a: assert property ($changed(acPower) && !$past(rst) && !$past(rst, 2) |=> smiPending)
        else $error("ac power change not pending");
    // without a write nothing may clear a pending cause
    hold_pending_a: assert property (smiPending && !avsWrite |=> smiPending)
        else $error("pending smi dropped without a write");
endmodule
bind pmes_event_select pmes_event_select_checker pmes_event_select_checker_i (.mclk(mclk), .rst(rst),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .acPower(acPower), .softwareSmiReq(softwareSmiReq), .globalStandbyExitReq(globalStandbyExitReq),
    .breakEvent(breakEvent), .breakSmi(breakSmi), .autoSuspendTrigger(autoSuspendTrigger),
    .smiPending(smiPending));
`default_nettype wire

// ===== sim/tb_pmes_event_select.sv
// self-checking bench for the event select and smi cause block
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module tb_pmes_event_select;
    import pmes_pkg::*;
    logic mclk = 0, rst = 1, avsRead = 0, avsWrite = 0, ringN = 1, extN = 1, acPower = 1;
    logic dmaRequest = 0, alarm = 0, hddAccess = 0, ioRead = 0, ioWrite = 0;
    logic avsWaitRequest, systemEvent, breakEvent, breakSmi, autoSuspendTrigger, smiPending, pendingSeen;
    logic [9:0] avsAddress = 10'h000;
    logic [31:0] avsWriteData = 32'h00000000, avsReadData;
    logic [15:0] irqLines = 16'h0000, smiCount;
    pmes_ioaddr_t ioAddr = 10'h000, win;
    logic [7:0] c0Req = 8'h00, rd, tmp, ctl, idx, winMask;
    logic [5:0] c1Req = 6'h00;
    logic [31:0] seed = 32'h490E3374;
    int errors = 0, samples_checked = 0, cycles = 0, expSmi = 0;
    int irqNum [13] = '{1, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15};
    pmes_ioaddr_t ports [5] = '{10'h3F8, 10'h2F8, 10'h378, 10'h278, 10'h3BC};
    logic [7:0] regIdx [10] = '{8'h5E, 8'h5F, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h80};
    pmes_event_select pmes_event_select_i (.mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .irqLines(irqLines), .dmaRequest(dmaRequest), .alarm(alarm),
        .ringN(ringN), .external_system_event_pinN(extN), .hddAccess(hddAccess), .ioAddr(ioAddr),
        .ioRead(ioRead), .ioWrite(ioWrite), .globalStandbyExitReq(c0Req[7]), .globalStandbyEnterReq(c0Req[6]),
        .displayStandbyExitReq(c0Req[5]), .displayStandbyEnterReq(c0Req[4]), .windowStandbyExitReq(c0Req[3]),
        .windowStandbyEnterReq(c0Req[2]), .diskStandbyExitReq(c0Req[1]), .diskStandbyEnterReq(c0Req[0]),
        .acPower(acPower), .extSmi1Req(c1Req[5]), .extSmi0Req(c1Req[4]), .softwareSmiReq(c1Req[3]),
        .batteryLowReq(c1Req[2]), .suspendButtonReq(c1Req[1]), .autoSuspendReq(c1Req[0]),
        .systemEvent(systemEvent), .breakEvent(breakEvent), .breakSmi(breakSmi),
        .autoSuspendTrigger(autoSuspendTrigger), .smiPending(smiPending));
    pmes_host_model pmes_host_model_i (.mclk(mclk), .rst(rst), .breakSmi(breakSmi), .smiPending(smiPending),
        .smiCount(smiCount), .pendingSeen(pendingSeen));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
    endfunction
    // outputs in order system, break, break smi, auto suspend trigger
    function automatic logic [3:0] ev_exp(input int p, input logic [7:0] c, input logic on);
        return on ? {p == 0, p == 1, p == 1 && c[0], p == 1 && c[0] && c[2]} : 4'h0;
    endfunction
    // the two ac power sources fill the top two bits of the second cause byte
    function automatic logic [15:0] cause_exp(input int j);
        return j < 14 ? 16'h0001 << j : 16'h0001 << (29 - j);
    endfunction
    task automatic end_sim;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one held request; a wait of any length ends only by the bench timeout
    task automatic bus(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
        @(posedge mclk);
        avsAddress <= {ix, 2'b00};
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= {24'h000000, wd};
        do @(posedge mclk); while (avsWaitRequest !== 1'b0);
        rd = avsReadData[7:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    // one cycle of activity on source i, then idle; outputs settled on return
    task automatic fire(input int i);
        @(posedge mclk);
        seed = lfsr(seed);
        if (i < 13) irqLines[irqNum[i]] <= 1'b1;
        if (i == 13) ringN <= 1'b0;
        if (i == 14) alarm <= 1'b1;
        if (i == 15) dmaRequest <= 1'b1;
        if (i >= 16 && i <= 20) ioAddr <= ports[i - 16] | (seed[9:0] & (i < 18 ? 10'h007 : 10'h003));
        if (i == 21) hddAccess <= 1'b1;
        if (i == 22) ioAddr <= {win[9:4], (win[3:0] & ~winMask[3:0]) | (seed[3:0] & winMask[3:0])};
        if (i == 23) extN <= 1'b0;
        ioWrite <= i >= 16 && i <= 22 && i != 21 && seed[10];
        ioRead <= i >= 16 && i <= 22 && i != 21 && !seed[10];
        @(posedge mclk);
        irqLines <= 16'h0000;
        {ringN, extN} <= 2'b11;
        {alarm, dmaRequest, hddAccess, ioRead, ioWrite} <= 5'h00;
        #1;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        // reset values, then an unmapped place that must read zero
        foreach (regIdx[k]) begin
            bus(0, regIdx[k], 8'h00);
            check("reset value", 0, rd);
        end
        bus(1, 8'h90, 8'hFF);
        bus(0, 8'h90, 8'h00);
        check("unmapped", 0, rd);
        for (int k = 2; k < 9; k++) begin
            seed = lfsr(seed);
            bus(1, regIdx[k], seed[7:0]);
            bus(0, regIdx[k], 8'h00);
            check("select rw", k < 7 ? seed[7:0] : 8'h00, rd);
            bus(1, regIdx[k], 8'h00);
        end
        // window in a random place with a random mask of the low bits
        seed = lfsr(seed);
        win = {2'b10, seed[7:0]};
        winMask = {4'h0, seed[11:8]};
        bus(1, 8'h5E, win[7:0]);
        bus(1, 8'h5F, {2'b00, winMask[3:0], win[9:8]});
        // each source on the break path and sources 8 to 23 on the system path, selected alone, then with its select clear
        for (int i = 0; i < 24; i++) begin
            for (int p = 0; p < 2; p++) begin
                if (p == 0 && i < 8) continue;
                idx = (p ? 8'h79 : 8'h76) + 8'(i / 8);
                seed = lfsr(seed);
                ctl = seed[7:0];
                bus(1, 8'h80, ctl);
                bus(1, idx, 8'h01 << (i % 8));
                fire(i);
                check("events", ev_exp(p, ctl, 1'b1), {systemEvent, breakEvent, breakSmi, autoSuspendTrigger});
                expSmi += (p == 1 && ctl[0]);
                bus(1, idx, 8'h00);
                fire(i);
                check("unselected", 0, {systemEvent, breakEvent, breakSmi, autoSuspendTrigger});
            end
        end
        // every cause bit: set, survive a write of ones to the first cause byte only, clear with zero
        for (int j = 0; j < 16; j++) begin
            @(posedge mclk);
            if (j < 8) c0Req[j] <= 1'b1;
            else if (j < 14) c1Req[j - 8] <= 1'b1;
            else acPower <= (j == 15);
            @(posedge mclk);
            c0Req <= 8'h00;
            c1Req <= 6'h00;
            bus(1, 8'h7C, 8'hFF);
            bus(0, 8'h7C, 8'h00);
            tmp = rd;
            bus(0, 8'h7D, 8'h00);
            check("cause", cause_exp(j), {rd, tmp});
            bus(1, 8'h7C, 8'h00);
            bus(1, 8'h7D, 8'h00);
            #1;
            check("pending cleared", 0, smiPending);
        end
        check("smi count", expSmi, smiCount);
        check("pending seen", 1, pendingSeen);
        end_sim();
    end
endmodule
`default_nettype wire
